// file: hw/bcp_defines.vh
`ifndef BCP_DEFINES_VH
`define BCP_DEFINES_VH

// ----------------------------------------
// register map
// ----------------------------------------
`define BCP_REG_PORT_CHARGE_ENABLE 8'hD0
`define BCP_CHG_EN_P1_BIT 1
`define BCP_CHG_EN_P2_BIT 2
`define BCP_CHG_EN_MASK 8'h06
`define BCP_CHG_EN_RESET 8'h00

// ----------------------------------------
// configuration timing
// ----------------------------------------
`define BCP_CFG_TIME_NS 2000
`define BCP_CLK_PERIOD_NS 50
`define BCP_CFG_CYCLES ((`BCP_CFG_TIME_NS + `BCP_CLK_PERIOD_NS - 1) / `BCP_CLK_PERIOD_NS)

`endif

// file: hw/bcp_port_power.v
// Overview of operation
// - charging-enabled ports get power as soon as reset and configuration finish.
// - that power needs neither enumeration nor the upstream vbus detect level.
// - an over-current on a port drops that port's power.
// - an over-current while unenumerated keeps the port off until host re-enable or reset.
// - a persisting short while attached is reported to the host as over-current status.
// - the charge-enable register at 0xD0 has bit 1 for port 1 and bit 2 for port 2.
// - in bus-configured mode, each port with its enable bit set has its power output driven on.
// - enables come from the port 1 strap or from bus-written register bits.
// - a strap sampled high means 1, sampled low means 0.
// - the led drive polarity on a shared strap pin follows the sampled strap value.
// - strap values count only when configuration selects straps, else ignored.
// - strap levels are captured when the active-low reset is released.
`timescale 1ns/1ps
`include "bcp_defines.vh"

module bcp_port_power #(
    parameter NUM_PORTS = 2,
    parameter CFG_CYCLES = `BCP_CFG_CYCLES
) (
    // clock and reset
    input wire i_clk_sys,
    input wire i_reset_n,
    // configuration select: 0 straps, 1 bus configured
    input wire i_cfg_sel,
    // strap and status pins
    input wire i_charge_enable_strap_p1,
    input wire i_upstream_vbus_detect,
    input wire [1:0] i_port_overcurrent_n,
    // host side events
    input wire i_hub_enumerated,
    input wire [1:0] i_host_port_power_on,
    input wire [1:0] i_host_port_power_off,
    // register port
    input wire i_reg_wr,
    input wire i_reg_rd,
    input wire [7:0] i_reg_addr,
    input wire [7:0] i_reg_wdata,
    output reg [7:0] o_reg_rdata,
    // outputs
    output reg [1:0] o_port_power_out,
    output reg [1:0] o_port_overcurrent_status,
    output reg o_led_active_high,
    output reg o_config_done
);

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    reg [4:0] sync1;
    reg [4:0] sync2;
    // no reset: pins keep flowing while reset is held, so the strap is settled at release
    always @(posedge i_clk_sys) begin
        sync1 <= {i_upstream_vbus_detect, i_cfg_sel, i_charge_enable_strap_p1,
                  ~i_port_overcurrent_n};
        sync2 <= sync1;
    end
    wire [1:0] oc = sync2[1:0];
    wire strap_p1 = sync2[2];
    wire cfg_sel = sync2[3];
    // vbus detect synchronised but deliberately unused for power gating

    // ----------------------------------------
    // configuration sequence after reset
    // ----------------------------------------
    localparam ST_CFG = 2'b01;
    localparam ST_RUN = 2'b10;
    localparam integer CFG_LAST_I = CFG_CYCLES - 1;
    localparam [15:0] CFG_LAST = CFG_LAST_I[15:0];
    reg [1:0] state;
    reg [1:0] next_state;
    reg [15:0] cfg_cnt;
    reg [15:0] next_cfg_cnt;
    always @* begin
        next_state = state;
        next_cfg_cnt = cfg_cnt;
        case (state)
            ST_CFG: begin
                if (cfg_cnt >= CFG_LAST) begin
                    next_state = ST_RUN; // configuration finished
                end else begin
                    next_cfg_cnt = cfg_cnt + 16'h0001;
                end
            end
            ST_RUN: begin
                next_state = ST_RUN;
            end
            default: begin
                next_state = ST_CFG;
                next_cfg_cnt = 16'h0000;
            end
        endcase
    end
    always @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            state <= ST_CFG;
            cfg_cnt <= 16'h0000;
        end else begin
            state <= next_state;
            cfg_cnt <= next_cfg_cnt;
        end
    end
    wire run = (state == ST_RUN);

    // ----------------------------------------
    // strap capture at reset release
    // ----------------------------------------
    reg strap_val;
    reg strap_valid;
    reg next_strap_val;
    always @* begin
        next_strap_val = strap_val;
        if (!strap_valid) begin
            // bus-configured hub ignores the pin, led polarity included
            next_strap_val = strap_p1 && !cfg_sel; // high is 1, low is 0
        end
    end
    always @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            strap_val <= 1'b0;
            strap_valid <= 1'b0;
        end else begin
            // first edge after release latches the level, later changes ignored
            strap_val <= next_strap_val;
            strap_valid <= 1'b1;
        end
    end

    // ----------------------------------------
    // charge-enable register
    // ----------------------------------------
    reg [7:0] chg_en;
    reg [7:0] next_chg_en;
    reg [7:0] next_rdata;
    wire hit = (i_reg_addr == `BCP_REG_PORT_CHARGE_ENABLE);
    always @* begin
        next_chg_en = chg_en;
        next_rdata = o_reg_rdata;
        if (i_reg_wr && hit) begin
            next_chg_en = i_reg_wdata & `BCP_CHG_EN_MASK;
        end
        // a read in the write's own cycle still returns the old value
        if (i_reg_rd) begin
            next_rdata = hit ? chg_en : 8'h00;
        end
    end
    always @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            chg_en <= `BCP_CHG_EN_RESET;
            o_reg_rdata <= 8'h00;
        end else begin
            chg_en <= next_chg_en;
            o_reg_rdata <= next_rdata;
        end
    end

    // strap feeds port 1 only, and only in strap mode
    wire [1:0] eff_en = cfg_sel ?
        {chg_en[`BCP_CHG_EN_P2_BIT], chg_en[`BCP_CHG_EN_P1_BIT]} :
        {1'b0, strap_val};

    // ----------------------------------------
    // per-port power and fault latch
    // ----------------------------------------
    reg [1:0] fault;
    reg [1:0] host_on;
    reg [1:0] next_fault;
    reg [1:0] next_host_on;
    reg [1:0] next_power;
    reg [1:0] next_status;
    integer p;
    always @* begin
        next_fault = fault;
        next_host_on = host_on;
        next_power = 2'b00;
        next_status = 2'b00;
        for (p = 0; p < NUM_PORTS; p = p + 1) begin
            // fault latch: set wins over host clear
            if (oc[p]) begin
                next_fault[p] = 1'b1;
            end else if (i_host_port_power_on[p]) begin
                next_fault[p] = 1'b0;
            end
            if (i_host_port_power_on[p]) begin
                next_host_on[p] = 1'b1;
            end else if (i_host_port_power_off[p]) begin
                next_host_on[p] = 1'b0;
            end
            // power regardless of enumeration or vbus detect
            next_power[p] = run && !oc[p] && !fault[p] && (eff_en[p] || host_on[p]);
            // report persisting short once attached
            next_status[p] = i_hub_enumerated && oc[p];
        end
    end
    always @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            fault <= 2'b00;
            host_on <= 2'b00;
        end else begin
            fault <= next_fault;
            host_on <= next_host_on;
        end
    end

    // ----------------------------------------
    // output registers
    // ----------------------------------------
    // a live oc also gates power directly, so the switch drops on the same edge that sets the latch
    always @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            o_port_power_out <= 2'b00;
            o_port_overcurrent_status <= 2'b00;
            o_led_active_high <= 1'b0;
            o_config_done <= 1'b0;
        end else begin
            o_port_power_out <= next_power;
            o_port_overcurrent_status <= next_status;
            o_led_active_high <= strap_val; // polarity from sampled strap
            o_config_done <= run;
        end
    end

endmodule

// file: testbench/bcp_port_power_chk.sv
`timescale 1ns/1ps
module bcp_chk (
    input wire i_clk_sys,
    input wire i_reset_n,
    input wire i_hub_enumerated,
    input wire [1:0] i_port_overcurrent_n,
    input wire i_reg_wr,
    input wire i_reg_rd,
    input wire [7:0] i_reg_addr,
    input wire [7:0] i_reg_wdata,
    input wire [7:0] o_reg_rdata,
    input wire [1:0] o_port_power_out,
    input wire [1:0] o_port_overcurrent_status,
    input wire o_config_done
);
    // ----------------
    // port and register checks
    // ----------------
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    a_oc_off_p1: assert property (
        !i_port_overcurrent_n[0] |-> ##3 !o_port_power_out[0])
        else $error("port 1 on in fault");
    a_oc_off_p2: assert property (
        !i_port_overcurrent_n[1] |-> ##3 !o_port_power_out[1])
        else $error("port 2 on in fault");
    a_no_early_power: assert property (!o_config_done |-> o_port_power_out == 2'h0)
        else $error("power before config");
    a_unused_bits: assert property ((o_reg_rdata & 8'hF9) == 8'h00)
        else $error("unused bit set");
    a_status_enum: assert property (
        !i_hub_enumerated [*2] |-> o_port_overcurrent_status == 2'h0)
        else $error("status while unattached");
    a_wr_readback: assert property (
        i_reg_wr && i_reg_addr == 8'hD0 ##1 i_reg_rd && i_reg_addr == 8'hD0
        |=> o_reg_rdata == ($past(i_reg_wdata, 2) & 8'h06))
        else $error("readback");
    a_rd_unmapped: assert property (
        i_reg_rd && i_reg_addr != 8'hD0 |=> o_reg_rdata == 8'h00)
        else $error("unmapped read");
    a_rdata_holds: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
        else $error("rdata moved");
endmodule
bind bcp_port_power bcp_chk chk_u (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_hub_enumerated(i_hub_enumerated),
    .i_port_overcurrent_n(i_port_overcurrent_n),
    .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd),
    .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata),
    .o_port_power_out(o_port_power_out),
    .o_port_overcurrent_status(o_port_overcurrent_status),
    .o_config_done(o_config_done)
);

// file: testbench/bcp_switch_model.sv
`timescale 1ns/1ps
module bcp_switch_model (
    input wire i_clk_sys,
    input wire [1:0] i_power,
    input wire [1:0] i_short,
    output reg [1:0] o_overcurrent_n = 2'h3
);
    // a real switch only trips while it is powered into the short
    always @(posedge i_clk_sys) o_overcurrent_n <= ~(i_power & i_short);
endmodule

// file: testbench/test_battery_charge_port_power.sv
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fail_count++; \
    $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module test_battery_charge_port_power;
    // ----------------
    // bench
    // ----------------
    logic clk = 0, rst_n = 0, sel = 0, strap = 1, enum_l = 0, wr = 0, rd = 0, vbus = 0, led, done;
    logic [1:0] on = 0, off = 0, short = 0, oc_n, pwr, st;
    logic [7:0] addr = 0, wdata = 0, rdata;
    int fail_count = 0, num_checks = 0, cyc = 0;
    always #25 clk = ~clk;
    bcp_port_power dut_u (.i_clk_sys(clk), .i_reset_n(rst_n), .i_cfg_sel(sel),
        .i_charge_enable_strap_p1(strap), .i_upstream_vbus_detect(vbus),
        .i_port_overcurrent_n(oc_n),
        .i_hub_enumerated(enum_l), .i_host_port_power_on(on), .i_host_port_power_off(off),
        .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
        .o_port_power_out(pwr), .o_port_overcurrent_status(st), .o_led_active_high(led),
        .o_config_done(done));
    bcp_switch_model sw_u (.i_clk_sys(clk), .i_power(pwr), .i_short(short), .o_overcurrent_n(oc_n));
    task automatic stop_test;
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic restart(input logic s, input logic p);
        @(posedge clk) {rst_n, sel, strap} <= {1'b0, s, p};
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        for (int k = 0; k < 60 && done !== 1'b1; k++) @(posedge clk);
        hold(2);
        `CHK(done, 1'b1)
    endtask
    // write (optional) then read straight after it
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
        @(posedge clk) {wr, addr, wdata} <= {w, a, d};
        @(posedge clk) {wr, rd} <= 2'b01;
        @(posedge clk) rd <= 1'b0;
        hold(1);
        `CHK(rdata, e)
    endtask
    always @(posedge clk) if (++cyc == 3000) begin
        fail_count++;
        stop_test();
    end
    initial begin
        restart(0, 1);
        `CHK({pwr, led}, 3'b011)
        @(posedge clk) short <= 2'h1;
        hold(6);
        `CHK(pwr, 2'h0)
        @(posedge clk) short <= 2'h0;
        hold(6);
        `CHK(pwr, 2'h0)
        @(posedge clk) on <= 2'h1;
        @(posedge clk) on <= 2'h0;
        hold(4);
        `CHK(pwr, 2'h1)
        restart(0, 0);
        `CHK({pwr, led}, 3'b000)
        @(posedge clk) vbus <= 1'b1;
        restart(1, 1);
        `CHK({pwr, led}, 3'b000)
        acc(0, 8'hD0, 8'h00, 8'h00);
        acc(1, 8'hD0, 8'hFF, 8'h06);
        acc(1, 8'h10, 8'hFF, 8'h00);
        acc(0, 8'hD0, 8'h00, 8'h06);
        `CHK(pwr, 2'h3)
        @(posedge clk) {enum_l, short} <= 3'b110;
        hold(6);
        `CHK({st, pwr}, 4'b1001)
        @(posedge clk) {enum_l, short} <= 3'b000;
        acc(1, 8'hD0, 8'h02, 8'h02);
        `CHK(pwr, 2'h1)
        @(posedge clk) on <= 2'h2;
        @(posedge clk) on <= 2'h0;
        hold(3);
        `CHK(pwr, 2'h3)
        @(posedge clk) off <= 2'h2;
        @(posedge clk) off <= 2'h0;
        hold(3);
        `CHK(pwr, 2'h1)
        stop_test();
    end
endmodule
